// File: rtl/bdg_glue.sv
// Notes on behaviour
// - rom sockets selected for 0000..0fff
// - 1k ram selected for 3c00..3fff
// - rom split into four 1k socket selects
// - other memory addresses go off-board
// - parallel ports e4..e7 and e8..eb
// - single interrupt level, acknowledge answers restart-7
// - six request sources merged into one level
// - request inputs asserted when low
// - peripheral requests pass through jumper gates
// - bit clock jumper picks one of eight
// - sync baud equals clock; async divides 16/64
// - sync characters handled by serial controller
// - async characters handled by serial controller
// - cpu clock 2.048 mhz, four clocks 1.95us
// - four peripheral requests individually maskable
// - peripheral requests signal buffer full/empty
`timescale 1ns/1ps
`default_nettype none
module bdg_glue
    import bdg_pkg::*;
(
    input  wire logic                 REF_CLK,
    input  wire logic                 RST,
    input  wire logic [15:0]          ADDR,
    input  wire logic                 MEM_RD_N,
    input  wire logic                 MEM_WR_N,
    input  wire logic                 IO_RD_N,
    input  wire logic                 IO_WR_N,
    input  wire logic                 INTA_N,
    input  wire logic                 USER_BUS_IRQ_N,
    input  wire logic                 USER_EDGE_IRQ_N,
    input  wire logic                 PARALLEL_A_IRQ_N,
    input  wire logic                 PARALLEL_B_IRQ_N,
    input  wire logic                 SERIAL_RXRDY_IRQ_N,
    input  wire logic                 SERIAL_TXEMPTY_IRQ_N,
    input  wire logic [IRQ_GATED-1:0] IRQ_JUMPER,
    input  wire logic [IRQ_GATED-1:0] IRQ_MASK,
    input  wire logic [BIT_SEL_W-1:0] BIT_CLK_JUMPER,
    input  wire logic                 ASYNC_DIV64_SEL,
    output logic [ROM_SOCKETS-1:0]    ROM_SEL_N,
    output logic                      RAM_SEL_N,
    output logic                      OFFBOARD_MEM,
    output logic                      PARALLEL_A_SEL_N,
    output logic                      PARALLEL_B_SEL_N,
    output logic [1:0]                PARALLEL_PORT,
    output logic                      SERIAL_SEL_N,
    output logic                      SERIAL_CTRL,
    output logic                      CPU_INT,
    output logic [7:0]                DATA_OUT,
    output logic                      DATA_OE,
    output logic                      CPU_CLK_EN,
    output logic                      SERIAL_BIT_TICK,
    output logic                      SERIAL_ASYNC_TICK
);
    logic                     mem_cyc;
    logic                     io_cyc;
    logic                     ack_cyc;
    logic                     in_rom;
    logic                     in_ram;
    logic                     in_par_a;
    logic                     in_par_b;
    logic                     in_ser;
    logic [IRQ_COUNT-1:0]     irq_raw_n;
    logic [SYNC_STAGES-1:0]   sync_ff [IRQ_COUNT];
    logic [IRQ_COUNT-1:0]     irq_ff;
    logic [IRQ_GATED-1:0]     gate_open;
    logic                     nxt_int;
    logic [PHASE_W:0]         cpu_acc_ff;
    logic [PHASE_W:0]         bit_acc_ff;
    logic [PHASE_W-1:0]       bit_step;
    logic [ASYNC_CNT_W-1:0]   async_cnt_ff;
    logic                     bit_tick;

    assign mem_cyc = !MEM_RD_N || !MEM_WR_N;
    assign io_cyc  = !IO_RD_N || !IO_WR_N;
    assign ack_cyc = !INTA_N;

    assign in_rom   = ADDR >= ROM_FIRST && ADDR <= ROM_LAST;
    assign in_ram   = ADDR >= RAM_FIRST && ADDR <= RAM_LAST;
    assign in_par_a = ADDR[7:0] >= PARALLEL_A_PORT_ONE && ADDR[7:0] <= PARALLEL_A_CONTROL;
    assign in_par_b = ADDR[7:0] >= PARALLEL_B_PORT_FOUR && ADDR[7:0] <= PARALLEL_B_CONTROL;
    assign in_ser   = ADDR[7:0] == SERIAL_DATA || ADDR[7:0] == SERIAL_CONTROL_STATUS;

    // memory selects; acknowledge cycles select nothing
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            ROM_SEL_N    <= '1;
            RAM_SEL_N    <= 1'b1;
            OFFBOARD_MEM <= 1'b0;
        end else begin
            ROM_SEL_N    <= '1;
            RAM_SEL_N    <= 1'b1;
            OFFBOARD_MEM <= 1'b0;
            if (mem_cyc && !ack_cyc) begin
                if (in_rom) begin
                    ROM_SEL_N[ADDR[SOCKET_LSB+1:SOCKET_LSB]] <= 1'b0;
                end else if (in_ram) begin
                    RAM_SEL_N <= 1'b0;
                end else begin
                    OFFBOARD_MEM <= 1'b1;
                end
            end
        end
    end

    // port selects; low two address bits pick the port inside a parallel chip, bit 0 picks the serial register
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            PARALLEL_A_SEL_N <= 1'b1;
            PARALLEL_B_SEL_N <= 1'b1;
            SERIAL_SEL_N     <= 1'b1;
            PARALLEL_PORT    <= 2'h0;
            SERIAL_CTRL      <= 1'b0;
        end else begin
            PARALLEL_A_SEL_N <= !(io_cyc && !ack_cyc && in_par_a);
            PARALLEL_B_SEL_N <= !(io_cyc && !ack_cyc && in_par_b);
            SERIAL_SEL_N     <= !(io_cyc && !ack_cyc && in_ser);
            PARALLEL_PORT    <= ADDR[1:0];
            SERIAL_CTRL      <= ADDR[0];
        end
    end

    // interrupt pins: three-stage synchroniser, change accepted when stages 2 and 3 agree
    assign irq_raw_n = {SERIAL_TXEMPTY_IRQ_N, SERIAL_RXRDY_IRQ_N, PARALLEL_B_IRQ_N,
                        PARALLEL_A_IRQ_N, USER_EDGE_IRQ_N, USER_BUS_IRQ_N};

    for (genvar i = 0; i < IRQ_COUNT; i++) begin : g_sync
        always_ff @(posedge REF_CLK) begin
            if (RST) begin
                sync_ff[i] <= '1;
                irq_ff[i]  <= 1'b0;
            end else begin
                sync_ff[i] <= {sync_ff[i][SYNC_STAGES-2:0], irq_raw_n[i]};
                if (sync_ff[i][1] == sync_ff[i][2]) begin
                    irq_ff[i] <= !sync_ff[i][2];
                end
            end
        end
    end

    // bits 2..5: parallel a, parallel b, serial rx ready, serial tx empty
    assign gate_open = IRQ_JUMPER & ~IRQ_MASK;
    assign nxt_int   = irq_ff[0] || irq_ff[1]
                    || |(irq_ff[IRQ_COUNT-1:2] & gate_open);

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            CPU_INT <= 1'b0;
        end else begin
            CPU_INT <= nxt_int;
        end
    end

    // acknowledge: drive restart-7 so the cpu vectors to 0038
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            DATA_OUT <= 8'h00;
            DATA_OE  <= 1'b0;
        end else begin
            DATA_OE  <= ack_cyc && !INTA_N;
            DATA_OUT <= ack_cyc ? RESTART7_OPCODE : 8'h00;
        end
    end

    // cpu clock enable: fractional divider, average 2.048 mhz
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            cpu_acc_ff <= '0;
        end else begin
            cpu_acc_ff <= {1'b0, cpu_acc_ff[PHASE_W-1:0]} + {1'b0, CPU_STEP};
        end
    end
    assign CPU_CLK_EN = cpu_acc_ff[PHASE_W];

    // serial bit clock from jumper code
    always_comb begin
        bit_step = phase_step(BIT_CLK_HZ[BIT_CLK_JUMPER]);
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            bit_acc_ff <= '0;
        end else begin
            bit_acc_ff <= {1'b0, bit_acc_ff[PHASE_W-1:0]} + {1'b0, bit_step};
        end
    end
    assign bit_tick        = bit_acc_ff[PHASE_W];
    // sync baud is the bit clock itself; controller framing rides on these ticks
    assign SERIAL_BIT_TICK = bit_tick;

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            async_cnt_ff <= '0;
        end else if (bit_tick) begin
            async_cnt_ff <= async_cnt_ff + 1'b1;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            SERIAL_ASYNC_TICK <= 1'b0;
        end else if (ASYNC_DIV64_SEL) begin
            SERIAL_ASYNC_TICK <= bit_tick && (&async_cnt_ff);
        end else begin
            SERIAL_ASYNC_TICK <= bit_tick && (&async_cnt_ff[3:0]);
        end
    end

    // helper counters for checks
    logic [7:0] cpu_gap_ff;
    logic [7:0] cpu_cnt4_ff;
    logic [7:0] four_len_ff;
    always_ff @(posedge REF_CLK) begin
        if (RST || CPU_CLK_EN) begin
            cpu_gap_ff <= 8'h01;
        end else if (cpu_gap_ff != 8'hff) begin
            cpu_gap_ff <= cpu_gap_ff + 8'h01;
        end
    end
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            cpu_cnt4_ff <= 8'h00;
            four_len_ff <= 8'h00;
        end else if (CPU_CLK_EN && cpu_cnt4_ff == 8'(FASTEST_INSTR_CLKS - 1)) begin
            cpu_cnt4_ff <= 8'h00;
            four_len_ff <= 8'h01;
        end else begin
            if (CPU_CLK_EN) begin
                cpu_cnt4_ff <= cpu_cnt4_ff + 8'h01;
            end
            if (four_len_ff != 8'hff) begin
                four_len_ff <= four_len_ff + 8'h01;
            end
        end
    end

    a_rom_socket_sel: assert property (@(posedge REF_CLK) disable iff (RST)
        (mem_cyc && !ack_cyc && ADDR <= ROM_LAST) |=> ROM_SEL_N == ~(4'h1 << $past(ADDR[11:10])))
        else $error("rom socket select wrong");
    a_ram_sel: assert property (@(posedge REF_CLK) disable iff (RST)
        !RAM_SEL_N |-> $past(mem_cyc) && $past(ADDR[15:10]) == RAM_FIRST[15:10])
        else $error("ram select outside its range");
    a_offboard_mem: assert property (@(posedge REF_CLK) disable iff (RST)
        OFFBOARD_MEM |-> (ROM_SEL_N == 4'hf && RAM_SEL_N && $past(ADDR) > ROM_LAST))
        else $error("off-board access selected on-board memory");
    a_par_a_sel: assert property (@(posedge REF_CLK) disable iff (RST)
        (io_cyc && !ack_cyc && ADDR[7:0] == PARALLEL_A_CONTROL) |=> !PARALLEL_A_SEL_N && PARALLEL_PORT == 2'h3)
        else $error("parallel a control not selected");
    a_ser_sel: assert property (@(posedge REF_CLK) disable iff (RST)
        !SERIAL_SEL_N |-> $past(ADDR[7:1]) == 7'h76 && SERIAL_CTRL == $past(ADDR[0]))
        else $error("serial select decode wrong");
    a_one_io_sel: assert property (@(posedge REF_CLK) disable iff (RST)
        $onehot0({!PARALLEL_A_SEL_N, !PARALLEL_B_SEL_N, !SERIAL_SEL_N}))
        else $error("more than one port select");
    a_vector_answer: assert property (@(posedge REF_CLK) disable iff (RST)
        ack_cyc |=> DATA_OE && DATA_OUT == RESTART7_OPCODE)
        else $error("acknowledge did not return restart-7");
    a_user_irq_low: assert property (@(posedge REF_CLK) disable iff (RST)
        (!USER_BUS_IRQ_N)[*5] |=> CPU_INT)
        else $error("low user request not raised");
    a_masked_quiet: assert property (@(posedge REF_CLK) disable iff (RST)
        (irq_ff[1:0] == 2'b00 && (irq_ff[5:2] & gate_open) == 4'h0) |=> !CPU_INT)
        else $error("masked or unjumpered request reached cpu");
    a_cpu_clk_gap: assert property (@(posedge REF_CLK) disable iff (RST)
        CPU_CLK_EN && !$past(RST, 12) |-> cpu_gap_ff >= CPU_GAP_MIN && cpu_gap_ff <= CPU_GAP_MAX)
        else $error("cpu clock spacing off");
    a_instr_time: assert property (@(posedge REF_CLK) disable iff (RST)
        (CPU_CLK_EN && cpu_cnt4_ff == 8'(FASTEST_INSTR_CLKS - 1) && four_len_ff != 8'h00
         && four_len_ff != 8'hff) |-> four_len_ff >= 8'(FASTEST_INSTR_CYC) && four_len_ff <= 8'(FASTEST_INSTR_CYC + 1))
        else $error("four cpu clocks not 1.95 us");
    a_async_div: assert property (@(posedge REF_CLK) disable iff (RST)
        SERIAL_ASYNC_TICK |-> $past(bit_tick))
        else $error("async tick without bit tick");
    // acknowledge cycles never reach the memory or port selects; i/o cycles never reach the memory selects
    a_ack_no_sel: assert property (@(posedge REF_CLK) disable iff (RST)
        ack_cyc |=> ROM_SEL_N == 4'hf && RAM_SEL_N && !OFFBOARD_MEM
                    && PARALLEL_A_SEL_N && PARALLEL_B_SEL_N && SERIAL_SEL_N)
        else $error("select active during acknowledge");
    a_data_idle: assert property (@(posedge REF_CLK) disable iff (RST)
        !ack_cyc |=> !DATA_OE && DATA_OUT == 8'h00)
        else $error("data driven outside acknowledge");
    a_io_not_mem: assert property (@(posedge REF_CLK) disable iff (RST)
        (io_cyc && !mem_cyc) |=> ROM_SEL_N == 4'hf && RAM_SEL_N && !OFFBOARD_MEM)
        else $error("i/o cycle selected memory");
    a_par_b_sel: assert property (@(posedge REF_CLK) disable iff (RST)
        (io_cyc && !ack_cyc && ADDR[7:0] == PARALLEL_B_PORT_FOUR)
        |=> !PARALLEL_B_SEL_N && PARALLEL_PORT == 2'h0)
        else $error("parallel b first port not selected");
    a_unmapped_io: assert property (@(posedge REF_CLK) disable iff (RST)
        (io_cyc && !(ADDR[7:0] inside {[PARALLEL_A_PORT_ONE:SERIAL_CONTROL_STATUS]}))
        |=> PARALLEL_A_SEL_N && PARALLEL_B_SEL_N && SERIAL_SEL_N)
        else $error("unmapped port selected a chip");
    a_gated_irq: assert property (@(posedge REF_CLK) disable iff (RST)
        (irq_ff[2] && gate_open[0]) |=> CPU_INT)
        else $error("open parallel a request not raised");

    c_rom_read:  cover property (@(posedge REF_CLK) disable iff (RST) !ROM_SEL_N[3]);
    c_ram_write: cover property (@(posedge REF_CLK) disable iff (RST) !RAM_SEL_N && !$past(MEM_WR_N));
    c_ser_ctrl:  cover property (@(posedge REF_CLK) disable iff (RST) !SERIAL_SEL_N && SERIAL_CTRL);
    c_int_ack:   cover property (@(posedge REF_CLK) disable iff (RST) CPU_INT ##[1:20] DATA_OE);
    c_async64:   cover property (@(posedge REF_CLK) disable iff (RST) SERIAL_ASYNC_TICK && ASYNC_DIV64_SEL);
endmodule
`default_nettype wire

// File: rtl/bdg_pkg.sv
package bdg_pkg;
    // processor memory map
    localparam logic [15:0] ROM_FIRST      = 16'h0000;
    localparam logic [15:0] ROM_LAST       = 16'h0fff;
    localparam logic [15:0] RAM_FIRST      = 16'h3c00;
    localparam logic [15:0] RAM_LAST       = 16'h3fff;
    localparam int          ROM_SOCKETS    = 4;
    localparam int          SOCKET_LSB     = 10;
    // port addresses
    localparam logic [7:0]  PARALLEL_A_PORT_ONE   = 8'he4;
    localparam logic [7:0]  PARALLEL_A_PORT_TWO   = 8'he5;
    localparam logic [7:0]  PARALLEL_A_PORT_THREE = 8'he6;
    localparam logic [7:0]  PARALLEL_A_CONTROL    = 8'he7;
    localparam logic [7:0]  PARALLEL_B_PORT_FOUR  = 8'he8;
    localparam logic [7:0]  PARALLEL_B_PORT_FIVE  = 8'he9;
    localparam logic [7:0]  PARALLEL_B_PORT_SIX   = 8'hea;
    localparam logic [7:0]  PARALLEL_B_CONTROL    = 8'heb;
    localparam logic [7:0]  SERIAL_DATA           = 8'hec;
    localparam logic [7:0]  SERIAL_CONTROL_STATUS = 8'hed;
    // interrupt acknowledge answer
    localparam logic [7:0]  RESTART7_OPCODE = 8'hff;
    localparam logic [15:0] RESTART7_TARGET = 16'h0038;
    localparam int          IRQ_COUNT       = 6;
    localparam int          IRQ_GATED       = 4;
    localparam int          SYNC_STAGES     = 3;
    // clocks
    localparam int          REF_CLK_HZ      = 20_000_000;
    localparam int          CPU_CLK_HZ      = 2_048_000;
    localparam int          FASTEST_INSTR_NS   = 1950;
    localparam int          FASTEST_INSTR_CLKS = 4;
    localparam int          FASTEST_INSTR_CYC  = (FASTEST_INSTR_NS * (REF_CLK_HZ / 1_000_000)) / 1000;
    localparam int          CPU_GAP_MIN     = REF_CLK_HZ / CPU_CLK_HZ;
    localparam int          CPU_GAP_MAX     = CPU_GAP_MIN + 1;
    localparam int          PHASE_W         = 24;
    localparam int          ASYNC_DIV16     = 16;
    localparam int          ASYNC_DIV64     = 64;
    localparam int          ASYNC_CNT_W     = 6;
    localparam int          BIT_SEL_W       = 3;
    // jumper code to serial bit clock in Hz
    localparam int          BIT_CLK_HZ [8] = '{307_200, 153_600, 76_800, 38_400, 19_200, 9_600, 4_800, 6_980};

    function automatic logic [PHASE_W-1:0] phase_step(input int hz);
        longint prod;
        prod = (longint'(hz) << PHASE_W) / longint'(REF_CLK_HZ);
        return prod[PHASE_W-1:0];
    endfunction

    localparam logic [PHASE_W-1:0] CPU_STEP = phase_step(CPU_CLK_HZ);
endpackage

// File: sim/bdg_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module bdg_cpu_model (
    input  wire logic   clk,
    output logic [15:0] addr,
    output logic        mem_rd_n,
    output logic        mem_wr_n,
    output logic        io_rd_n,
    output logic        io_wr_n,
    output logic        inta_n,
    output logic [5:0]  irq_n
);
    initial begin
        addr = 16'h5a5a;
        {mem_rd_n, mem_wr_n, io_rd_n, io_wr_n, inta_n} = 5'h1f;
        irq_n = 6'h3f;
    end
    // kind 0 mem read, 1 mem write, 2 io read, 3 io write, 4 acknowledge,
    // 5 acknowledge together with a memory read
    task automatic start(input int kind, input logic [15:0] a);
        @(posedge clk);
        #1;
        addr = a;
        {mem_rd_n, mem_wr_n, io_rd_n, io_wr_n, inta_n} = (kind == 5) ? 5'h0e : ~(5'h10 >> kind);
        @(posedge clk);
        #1;
    endtask
    task automatic finish();
        @(posedge clk);
        #1;
        {mem_rd_n, mem_wr_n, io_rd_n, io_wr_n, inta_n} = 5'h1f;
        // released address lines do not keep the last value
        addr = ~addr;
        @(posedge clk);
        #1;
    endtask
    // request lines idle high on pull-ups, a source pulls low to ask
    task automatic request(input int idx, input logic lvl);
        @(posedge clk);
        #1;
        irq_n[idx] = lvl;
    endtask
endmodule
`default_nettype wire

// File: sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import bdg_pkg::*;
    localparam int LIMIT = 80000;
    logic        ref_clk, rst, mem_rd_n, mem_wr_n, io_rd_n, io_wr_n, inta_n, div64;
    logic [15:0] addr;
    logic [5:0]  irq_n;
    logic [3:0]  irq_jumper, irq_mask, rom_sel_n;
    logic [2:0]  bit_jumper;
    logic [1:0]  par_port;
    logic [7:0]  data_out;
    logic        ram_sel_n, offb, pa_sel_n, pb_sel_n, ser_sel_n, ser_ctrl, cpu_int, data_oe;
    logic        cpu_clk_en, bit_tick, async_tick;
    int          n_mismatch, tests_run, cycles;
    int          hz [8] = '{307200, 153600, 76800, 38400, 19200, 9600, 4800, 6980};
    logic [15:0] mem_addr [12] = '{16'h0000, 16'h03ff, 16'h0400, 16'h0bff, 16'h0c00, 16'h0fff,
                                   16'h1000, 16'h3bff, 16'h3c00, 16'h3fff, 16'h4000, 16'hffff};

    bdg_cpu_model cpu (.clk(ref_clk), .addr(addr), .mem_rd_n(mem_rd_n), .mem_wr_n(mem_wr_n),
        .io_rd_n(io_rd_n), .io_wr_n(io_wr_n), .inta_n(inta_n), .irq_n(irq_n));
    bdg_glue uut (.REF_CLK(ref_clk), .RST(rst), .ADDR(addr), .MEM_RD_N(mem_rd_n), .MEM_WR_N(mem_wr_n),
        .IO_RD_N(io_rd_n), .IO_WR_N(io_wr_n), .INTA_N(inta_n), .USER_BUS_IRQ_N(irq_n[0]),
        .USER_EDGE_IRQ_N(irq_n[1]), .PARALLEL_A_IRQ_N(irq_n[2]), .PARALLEL_B_IRQ_N(irq_n[3]),
        .SERIAL_RXRDY_IRQ_N(irq_n[4]), .SERIAL_TXEMPTY_IRQ_N(irq_n[5]), .IRQ_JUMPER(irq_jumper),
        .IRQ_MASK(irq_mask), .BIT_CLK_JUMPER(bit_jumper), .ASYNC_DIV64_SEL(div64),
        .ROM_SEL_N(rom_sel_n), .RAM_SEL_N(ram_sel_n), .OFFBOARD_MEM(offb),
        .PARALLEL_A_SEL_N(pa_sel_n), .PARALLEL_B_SEL_N(pb_sel_n), .PARALLEL_PORT(par_port),
        .SERIAL_SEL_N(ser_sel_n), .SERIAL_CTRL(ser_ctrl), .CPU_INT(cpu_int), .DATA_OUT(data_out),
        .DATA_OE(data_oe), .CPU_CLK_EN(cpu_clk_en), .SERIAL_BIT_TICK(bit_tick),
        .SERIAL_ASYNC_TICK(async_tick));

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic idle_check();
        check("idle", 16'({rom_sel_n, ram_sel_n, pa_sel_n, pb_sel_n, ser_sel_n, offb}), 16'h01fe);
        check("idle ack", 16'({cpu_int, data_oe}), 16'h0000);
    endtask

    task automatic t_memory();
        logic [15:0] a;
        logic [3:0]  rom;
        logic        ram;
        for (int i = 0; i < 12; i++) begin
            a = mem_addr[i];
            rom = 4'hf;
            if (a <= ROM_LAST)
                rom[a[11:10]] = 1'b0;
            ram = a >= RAM_FIRST && a <= RAM_LAST;
            cpu.start(i % 2, a);
            check("rom sockets", 16'(rom_sel_n), 16'(rom));
            check("ram select", 16'(ram_sel_n), 16'(!ram));
            check("off-board", 16'(offb), 16'(rom == 4'hf && !ram));
        end
        cpu.finish();
        idle_check();
    endtask

    task automatic t_io();
        logic [7:0] a;
        logic       pa, pb, sr;
        for (int i = 0; i < 14; i++) begin
            a = 8'he2 + 8'(i);
            pa = a >= 8'he4 && a <= 8'he7;
            pb = a >= 8'he8 && a <= 8'heb;
            sr = a == 8'hec || a == 8'hed;
            // upper byte inside ram range: must not select memory
            cpu.start(2 + i % 2, {8'h3c, a});
            check("parallel sel", 16'({pa_sel_n, pb_sel_n}), 16'({!pa, !pb}));
            if (pa || pb)
                check("parallel port", 16'(par_port), 16'(a[1:0]));
            check("serial sel", 16'(ser_sel_n), 16'(!sr));
            if (sr)
                check("serial reg", 16'(ser_ctrl), 16'(a[0]));
            check("mem quiet", 16'({rom_sel_n, ram_sel_n, offb}), 16'h003e);
        end
        cpu.finish();
        idle_check();
    endtask

    task automatic t_irq();
        for (int i = 0; i < 6; i++) begin
            for (int m = 0; m < 3; m++) begin
                if (i < 2 && m > 0)
                    continue;
                // user sources must pass even with every gate closed
                irq_jumper = (i < 2) ? 4'h0 : 4'hf;
                irq_mask = (i < 2) ? 4'hf : 4'h0;
                if (m == 1)
                    irq_jumper[i-2] = 1'b0;
                if (m == 2)
                    irq_mask[i-2] = 1'b1;
                cpu.request(i, 1'b0);
                repeat (5) @(posedge ref_clk);
                #1;
                check("int level", 16'(cpu_int), 16'(m == 0));
                if (m == 0) begin
                    // odd sources see an acknowledge that also carries a memory read
                    cpu.start(4 + i % 2, 16'h0038);
                    check("ack byte", 16'({data_oe, data_out}), 16'h01ff);
                    check("ack vector", 16'({data_out[5:3], 3'b000}), RESTART7_TARGET);
                    check("ack no mem", 16'({rom_sel_n, ram_sel_n, offb}), 16'h003e);
                    check("ack no port", 16'({pa_sel_n, pb_sel_n, ser_sel_n}), 16'h0007);
                    cpu.finish();
                    check("ack end", 16'({data_oe, data_out}), 16'h0000);
                end
                cpu.request(i, 1'b1);
                repeat (6) @(posedge ref_clk);
                #1;
                check("int released", 16'(cpu_int), 16'h0000);
            end
        end
    endtask

    // which: 0 bit tick, 1 async tick, 2 cpu clock enable
    task automatic next_gap(input int which, output int cyc);
        cyc = 0;
        do begin
            @(posedge ref_clk);
            #1;
            cyc++;
        end while (cyc < 6000 && (which == 0 ? bit_tick : which == 1 ? async_tick : cpu_clk_en) !== 1'b1);
    endtask

    task automatic t_ticks();
        int g, n, bad, sum;
        bad = 0;
        sum = 0;
        next_gap(2, g);
        for (int k = 0; k < 204; k++) begin
            next_gap(2, g);
            sum += g;
            bad += int'(g < 9 || g > 10);
        end
        check("cpu gaps", 16'(bad), 16'h0000);
        check("cpu rate", 16'(sum >= 1992 && sum <= 1993), 16'h0001);
        for (int j = 0; j < 8; j++) begin
            bit_jumper = 3'(j);
            next_gap(0, g);
            next_gap(0, g);
            next_gap(0, g);
            n = 20000000 / hz[j];
            check("bit period", 16'(g == n || g == n + 1), 16'h0001);
        end
        bit_jumper = 3'h0;
        for (int d = 0; d < 2; d++) begin
            div64 = d[0];
            next_gap(1, g);
            next_gap(1, g);
            n = 0;
            do begin
                @(posedge ref_clk);
                #1;
                n += int'(bit_tick === 1'b1);
            end while (async_tick !== 1'b1 && n < 100);
            check("async ratio", 16'(n), d ? 16'h0040 : 16'h0010);
        end
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            n_mismatch++;
            final_report();
        end
    end

    initial begin
        rst = 1'b1;
        irq_jumper = 4'hf;
        irq_mask = 4'h0;
        bit_jumper = 3'h0;
        div64 = 1'b0;
        repeat (12) @(posedge ref_clk);
        #1;
        rst = 1'b0;
        idle_check();
        t_memory();
        t_io();
        t_irq();
        t_ticks();
        final_report();
    end
endmodule
`default_nettype wire
